// ### hpsc_pkg.sv
`default_nettype none
package hpsc_pkg;

  // ==========================================================================
  // Port change field bit positions.
  localparam int unsigned CHG_CONNECT_BIT    = 0;
  localparam int unsigned CHG_OVERCUR_BIT    = 3;
  localparam int unsigned CHG_RESET_BIT      = 4;
  localparam int unsigned CHG_WARM_RESET_BIT = 5;
  localparam int unsigned CHG_LINK_STATE_BIT = 6;
  localparam int unsigned CHG_CFG_ERR_BIT    = 7;
  localparam logic [15:0] CHG_IMPL_MASK      = 16'h00f9;
  localparam logic [15:0] CHG_RESET_VAL      = 16'h0000;

  // ==========================================================================
  // Feature selectors carried by the request port.
  localparam logic [4:0] FEAT_CONNECTION    = 5'h00;
  localparam logic [4:0] FEAT_OVER_CURRENT  = 5'h03;
  localparam logic [4:0] FEAT_RESET         = 5'h04;
  localparam logic [4:0] FEAT_LINK_STATE    = 5'h05;
  localparam logic [4:0] FEAT_POWER         = 5'h08;
  localparam logic [4:0] FEAT_C_CONNECTION  = 5'h10;
  localparam logic [4:0] FEAT_C_OVERCUR     = 5'h13;
  localparam logic [4:0] FEAT_C_RESET       = 5'h14;
  localparam logic [4:0] FEAT_C_LINK_STATE  = 5'h19;
  localparam logic [4:0] FEAT_C_CFG_ERR     = 5'h1a;
  localparam logic [4:0] FEAT_WARM_RESET    = 5'h1c;
  localparam logic [4:0] FEAT_C_WARM_RESET  = 5'h1d;

  // ==========================================================================
  // Reset values and fixed codes.
  localparam logic [2:0] SPEED_5G           = 3'h0;
  localparam logic [3:0] LINK_STATE_RST     = 4'h0;
  localparam logic       POWER_RST          = 1'b0;
  localparam logic       PER_PORT_OC        = 1'b1;
  localparam logic       DIAG_SET_SUPPORTED = 1'b1;

  // Downstream port state as reported by the port state machine.
  typedef enum logic [2:0] {
    PS_POWERED_OFF = 3'b000,
    PS_DISCONNECT  = 3'b001,
    PS_RESETTING   = 3'b010,
    PS_ENABLED     = 3'b011,
    PS_ERROR       = 3'b100,
    PS_DISABLED    = 3'b101
  } hpsc_port_state_t;

endpackage
`default_nettype wire

// ### hub_port_status_change.sv
`default_nettype none
module hub_port_status_change (
  // Clock and reset.
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // Feature request from the hub controller, one-cycle strobes.
  input  wire logic                      setFeature,
  input  wire logic                      clrFeature,
  input  wire logic [4:0]                featureSel,
  // Hub status word flags and port state machine inputs.
  input  wire logic                      hubLocalPowerChange,
  input  wire logic                      hubLocalPowerStatus,
  input  wire hpsc_pkg::hpsc_port_state_t portState,
  input  wire logic                      resetEntryOk,
  input  wire logic [3:0]                linkState,
  input  wire logic                      overCurrent,
  input  wire logic                      linkStateEvent,
  input  wire logic                      linkConfigFail,
  input  wire logic                      warmResetActive,
  // Status towards the request handler.
  output logic                           resetStatus,
  output logic                           enabledStatus,
  output logic                           connectStatus,
  output logic                           overCurrentStatus,
  output logic                           powerStatus,
  output logic [3:0]                     linkStateStatus,
  output logic [2:0]                     speedStatus,
  output logic [15:0]                    portChangeField,
  // Commands to the port state machine, one-cycle pulses.
  output logic                           startReset,
  output logic                           startWarmReset
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic       reset;
    logic       enabled;
    logic       connect;
    logic       overCur;
    logic       power;
    logic [3:0] link;
    logic [15:0] change;
    logic       warmPending;
    logic       startRst;
    logic       startWarm;
  } hpsc_state_t;

  localparam hpsc_state_t STATE_RST = '{
    reset: 1'b0, enabled: 1'b0, connect: 1'b0, overCur: 1'b0,
    power: hpsc_pkg::POWER_RST, link: hpsc_pkg::LINK_STATE_RST,
    change: hpsc_pkg::CHG_RESET_VAL, warmPending: 1'b0,
    startRst: 1'b0, startWarm: 1'b0};

  localparam logic PER_PORT_OC_C = hpsc_pkg::PER_PORT_OC;
  localparam logic DIAG_C        = hpsc_pkg::DIAG_SET_SUPPORTED;

  hpsc_state_t st_r;
  hpsc_state_t st_nxt;

  logic [15:0] chgSet;
  logic [15:0] chgClr;
  logic        nowReset;
  logic        nowEnabled;
  logic        nowConnect;
  logic        nowPoweredOff;

  // ==========================================================================
  // Next state.
  always_comb begin
    st_nxt        = st_r;
    chgSet        = 16'h0000;
    chgClr        = 16'h0000;
    nowReset      = (portState == hpsc_pkg::PS_RESETTING);
    nowEnabled    = (portState == hpsc_pkg::PS_ENABLED);
    nowConnect    = nowEnabled | nowReset | (portState == hpsc_pkg::PS_ERROR);
    nowPoweredOff = (portState == hpsc_pkg::PS_POWERED_OFF);

    st_nxt.reset    = nowReset;
    st_nxt.enabled  = nowEnabled;
    st_nxt.connect  = nowConnect;
    st_nxt.overCur  = overCurrent;
    st_nxt.link     = linkState;
    st_nxt.startRst = 1'b0;
    st_nxt.startWarm = 1'b0;

    // Warm reset is remembered while resetting so its completion can be told apart.
    if (nowReset && warmResetActive) begin
      st_nxt.warmPending = 1'b1;
    end else if (!nowReset) begin
      st_nxt.warmPending = 1'b0;
    end

    // Autonomous events and diagnostic set requests set change bits; other request results do not.
    if (nowConnect != st_r.connect && nowEnabled) begin
      chgSet[hpsc_pkg::CHG_CONNECT_BIT] = 1'b1;
    end
    if (PER_PORT_OC_C && (overCurrent != st_r.overCur)) begin
      chgSet[hpsc_pkg::CHG_OVERCUR_BIT] = 1'b1;
    end
    if (st_r.reset && nowEnabled) begin
      chgSet[hpsc_pkg::CHG_RESET_BIT] = 1'b1;
      chgSet[hpsc_pkg::CHG_WARM_RESET_BIT] = st_r.warmPending;
    end
    if (linkStateEvent) begin
      chgSet[hpsc_pkg::CHG_LINK_STATE_BIT] = 1'b1;
    end
    if (linkConfigFail) begin
      chgSet[hpsc_pkg::CHG_CFG_ERR_BIT] = 1'b1;
    end

    if (setFeature) begin
      case (featureSel)
        hpsc_pkg::FEAT_RESET: begin
          st_nxt.startRst = resetEntryOk;
        end
        hpsc_pkg::FEAT_WARM_RESET: begin
          st_nxt.startWarm = resetEntryOk;
        end
        hpsc_pkg::FEAT_POWER: begin
          if (!(hubLocalPowerChange && hubLocalPowerStatus)) begin
            st_nxt.power = 1'b1;
          end
        end
        hpsc_pkg::FEAT_C_CONNECTION: chgSet[hpsc_pkg::CHG_CONNECT_BIT] |= DIAG_C;
        hpsc_pkg::FEAT_C_OVERCUR:    chgSet[hpsc_pkg::CHG_OVERCUR_BIT] |= DIAG_C;
        hpsc_pkg::FEAT_C_RESET:      chgSet[hpsc_pkg::CHG_RESET_BIT] |= DIAG_C;
        hpsc_pkg::FEAT_C_WARM_RESET: chgSet[hpsc_pkg::CHG_WARM_RESET_BIT] |= DIAG_C;
        hpsc_pkg::FEAT_C_LINK_STATE: chgSet[hpsc_pkg::CHG_LINK_STATE_BIT] |= DIAG_C;
        hpsc_pkg::FEAT_C_CFG_ERR:    chgSet[hpsc_pkg::CHG_CFG_ERR_BIT] |= DIAG_C;
        default: begin
        end
      endcase
    end

    // Clears of reset, link state and other status features fall to default.
    if (clrFeature) begin
      case (featureSel)
        hpsc_pkg::FEAT_C_CONNECTION: chgClr[hpsc_pkg::CHG_CONNECT_BIT] = 1'b1;
        hpsc_pkg::FEAT_C_OVERCUR:    chgClr[hpsc_pkg::CHG_OVERCUR_BIT] = 1'b1;
        hpsc_pkg::FEAT_C_RESET:      chgClr[hpsc_pkg::CHG_RESET_BIT] = 1'b1;
        hpsc_pkg::FEAT_C_WARM_RESET: chgClr[hpsc_pkg::CHG_WARM_RESET_BIT] = 1'b1;
        hpsc_pkg::FEAT_C_LINK_STATE: chgClr[hpsc_pkg::CHG_LINK_STATE_BIT] = 1'b1;
        hpsc_pkg::FEAT_C_CFG_ERR:    chgClr[hpsc_pkg::CHG_CFG_ERR_BIT] = 1'b1;
        default: begin
        end
      endcase
    end

    // A hardware event in the clear cycle survives: set wins over clear.
    st_nxt.change = ((st_r.change & ~chgClr) | chgSet) & hpsc_pkg::CHG_IMPL_MASK;

    // Entering powered-off drops logical power, and power off holds the
    // power-related change bits clear.
    if (nowPoweredOff) begin
      st_nxt.power = 1'b0;
    end
    if (!st_r.power) begin
      st_nxt.change[hpsc_pkg::CHG_RESET_BIT]      = 1'b0;
      st_nxt.change[hpsc_pkg::CHG_WARM_RESET_BIT] = 1'b0;
      st_nxt.change[hpsc_pkg::CHG_LINK_STATE_BIT] = 1'b0;
      st_nxt.change[hpsc_pkg::CHG_CFG_ERR_BIT]    = 1'b0;
      if (nowPoweredOff) begin
        st_nxt.change[hpsc_pkg::CHG_OVERCUR_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  always_comb begin
    resetStatus       = st_r.reset;
    enabledStatus     = st_r.enabled;
    connectStatus     = st_r.connect;
    overCurrentStatus = st_r.overCur;
    powerStatus       = st_r.power;
    linkStateStatus   = st_r.link;
    speedStatus       = hpsc_pkg::SPEED_5G;
    portChangeField   = st_r.change;
    startReset        = st_r.startRst;
    startWarmReset    = st_r.startWarm;
  end

  // ==========================================================================
  // Checks.
  AST_RESET_TRACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 ##1 resetStatus == ($past(portState) == hpsc_pkg::PS_RESETTING))
    else $error("reset status does not track resetting state");
  AST_ENABLE_TRACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 ##1 enabledStatus == ($past(portState) == hpsc_pkg::PS_ENABLED))
    else $error("enabled status does not track enabled state");
  AST_START_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setFeature && featureSel == hpsc_pkg::FEAT_RESET && resetEntryOk |=> startReset)
    else $error("reset request did not start reset");
  AST_LINK_TRACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> linkStateStatus == $past(linkState))
    else $error("link state not presented");
  AST_POWER_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    portState == hpsc_pkg::PS_POWERED_OFF |=> !powerStatus)
    else $error("power bit not cleared in powered-off");
  AST_POWER_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setFeature && featureSel == hpsc_pkg::FEAT_POWER && hubLocalPowerChange
    && hubLocalPowerStatus && !powerStatus |=> !powerStatus)
    else $error("power set despite local power flags");
  AST_SPEED_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    speedStatus == hpsc_pkg::SPEED_5G)
    else $error("speed field changed");
  AST_RESET_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resetStatus && portState == hpsc_pkg::PS_ENABLED && powerStatus
    |=> portChangeField[hpsc_pkg::CHG_RESET_BIT])
    else $error("reset completion not flagged");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_C_CFG_ERR && !linkConfigFail
    |=> !portChangeField[hpsc_pkg::CHG_CFG_ERR_BIT])
    else $error("config error change not cleared");
  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (portChangeField & ~hpsc_pkg::CHG_IMPL_MASK) == 16'h0000)
    else $error("reserved change bit set");
  AST_CFG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkConfigFail && powerStatus |=> portChangeField[hpsc_pkg::CHG_CFG_ERR_BIT])
    else $error("config failure not flagged");

  // ==========================================================================
  // Change bit setting.
  // Entry into enabled from a not-connected state is the only connect change flagged.
  AST_CONNECT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    portState == hpsc_pkg::PS_ENABLED && !connectStatus
    |=> portChangeField[hpsc_pkg::CHG_CONNECT_BIT])
    else $error("connect change not flagged");

  AST_OC_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> overCurrentStatus == $past(overCurrent))
    else $error("over-current status not presented");

  AST_OVERCUR_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overCurrent != overCurrentStatus
    && !(portState == hpsc_pkg::PS_POWERED_OFF && !powerStatus)
    |=> portChangeField[hpsc_pkg::CHG_OVERCUR_BIT])
    else $error("over-current change not flagged");

  AST_WARM_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(resetStatus && portState == hpsc_pkg::PS_ENABLED)
    && !(setFeature && featureSel == hpsc_pkg::FEAT_C_WARM_RESET)
    && !portChangeField[hpsc_pkg::CHG_WARM_RESET_BIT]
    |=> !portChangeField[hpsc_pkg::CHG_WARM_RESET_BIT])
    else $error("warm reset change set without warm reset completion");

  AST_LINK_EVT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkStateEvent && powerStatus |=> portChangeField[hpsc_pkg::CHG_LINK_STATE_BIT])
    else $error("link state change not flagged");

  AST_DIAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setFeature && featureSel == hpsc_pkg::FEAT_C_LINK_STATE && powerStatus
    |=> portChangeField[hpsc_pkg::CHG_LINK_STATE_BIT])
    else $error("diagnostic set of change bit ignored");

  AST_NO_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !setFeature && !linkStateEvent && !linkConfigFail
    && overCurrent == overCurrentStatus && portState != hpsc_pkg::PS_ENABLED
    |=> (portChangeField & ~$past(portChangeField)) == 16'h0000)
    else $error("change bit set without an event");

  AST_POWER_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !powerStatus |=> !portChangeField[hpsc_pkg::CHG_RESET_BIT]
    && !portChangeField[hpsc_pkg::CHG_WARM_RESET_BIT])
    else $error("reset change bits not held clear without power");

  // ==========================================================================
  // Requests.
  AST_START_WARM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setFeature && featureSel == hpsc_pkg::FEAT_WARM_RESET && resetEntryOk
    |=> startWarmReset)
    else $error("warm reset request did not start warm reset");

  AST_NO_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(setFeature && resetEntryOk) |=> !startReset && !startWarmReset)
    else $error("reset started without an allowed request");

  AST_CLR_RST_NOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_RESET
    |=> !startReset && !startWarmReset)
    else $error("clear of reset feature had an effect");

  AST_CLR_LINK_NOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && featureSel == hpsc_pkg::FEAT_LINK_STATE
    |=> linkStateStatus == $past(linkState))
    else $error("clear of link state feature had an effect");

  AST_POWER_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setFeature && featureSel == hpsc_pkg::FEAT_POWER
    && !(hubLocalPowerChange && hubLocalPowerStatus)
    && portState != hpsc_pkg::PS_POWERED_OFF |=> powerStatus)
    else $error("power request did not set power bit");

  // ==========================================================================
  // Change bit clearing. An event in the clear cycle wins, so it is excluded.
  AST_CONNECT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_C_CONNECTION
    && !(portState == hpsc_pkg::PS_ENABLED && !connectStatus)
    |=> !portChangeField[hpsc_pkg::CHG_CONNECT_BIT])
    else $error("connect change not cleared");

  AST_OC_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_C_OVERCUR
    && overCurrent == overCurrentStatus
    |=> !portChangeField[hpsc_pkg::CHG_OVERCUR_BIT])
    else $error("over-current change not cleared");

  AST_RESET_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_C_RESET
    && !(resetStatus && portState == hpsc_pkg::PS_ENABLED)
    |=> !portChangeField[hpsc_pkg::CHG_RESET_BIT])
    else $error("reset change not cleared");

  AST_WARM_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_C_WARM_RESET
    && !(resetStatus && portState == hpsc_pkg::PS_ENABLED)
    |=> !portChangeField[hpsc_pkg::CHG_WARM_RESET_BIT])
    else $error("warm reset change not cleared");

  AST_LINK_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clrFeature && !setFeature && featureSel == hpsc_pkg::FEAT_C_LINK_STATE
    && !linkStateEvent |=> !portChangeField[hpsc_pkg::CHG_LINK_STATE_BIT])
    else $error("link state change not cleared");

  COV_RESET_DONE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    resetStatus ##1 enabledStatus);
  COV_POWER_ON: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !powerStatus ##1 powerStatus);
  COV_CLEAR_CHANGE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    portChangeField[hpsc_pkg::CHG_CONNECT_BIT] ##1 !portChangeField[hpsc_pkg::CHG_CONNECT_BIT]);
  COV_WARM_DONE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !portChangeField[hpsc_pkg::CHG_WARM_RESET_BIT] ##1 portChangeField[hpsc_pkg::CHG_WARM_RESET_BIT]);

endmodule // hub_port_status_change
`default_nettype wire

// ### hpsc_host_model.sv
`default_nettype none
module hpsc_host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Feature request towards the hub port.
  output var  logic       setFeature,
  output var  logic       clrFeature,
  output var  logic [4:0] featureSel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    setFeature = 1'b0;
    clrFeature = 1'b0;
    featureSel = 5'h1f;
  end

  // ==========================================================================
  // One request a call, launched on a falling edge and held for one clock.
  // Clears of reset or link state are sent only when a test asks for them.
  task automatic request(input logic isSet, input logic [4:0] sel);
    @(negedge sys_clk);
    setFeature = isSet;
    clrFeature = !isSet;
    featureSel = sel;
    @(negedge sys_clk);
    setFeature = 1'b0;
    clrFeature = 1'b0;
    // The selector is not held after the strobe, so a stale value cannot pass.
    featureSel = ~sel;
  endtask
endmodule // hpsc_host_model
`default_nettype wire

// ### testbench.sv
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic setFeature, clrFeature, hubLocalPowerChange, hubLocalPowerStatus;
  logic resetEntryOk, overCurrent, linkStateEvent, linkConfigFail, warmResetActive;
  logic resetStatus, enabledStatus, connectStatus, overCurrentStatus, powerStatus;
  logic startReset, startWarmReset;
  logic [4:0] featureSel;
  logic [3:0] linkState, linkStateStatus;
  logic [2:0] speedStatus;
  logic [15:0] portChangeField;
  hpsc_pkg::hpsc_port_state_t portState;
  int failures = 0;
  int comparisons = 0;
  int evBit [3] = '{3, 6, 7};
  logic [4:0] evClr [3] = '{hpsc_pkg::FEAT_C_OVERCUR, hpsc_pkg::FEAT_C_LINK_STATE,
                            hpsc_pkg::FEAT_C_CFG_ERR};

  always #2 sys_clk = ~sys_clk;

  hpsc_host_model hpsc_host_model_i (.sys_clk(sys_clk), .setFeature(setFeature),
    .clrFeature(clrFeature), .featureSel(featureSel));

  hub_port_status_change hub_port_status_change_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .setFeature(setFeature), .clrFeature(clrFeature), .featureSel(featureSel),
    .hubLocalPowerChange(hubLocalPowerChange), .hubLocalPowerStatus(hubLocalPowerStatus),
    .portState(portState), .resetEntryOk(resetEntryOk), .linkState(linkState),
    .overCurrent(overCurrent), .linkStateEvent(linkStateEvent),
    .linkConfigFail(linkConfigFail), .warmResetActive(warmResetActive),
    .resetStatus(resetStatus), .enabledStatus(enabledStatus),
    .connectStatus(connectStatus), .overCurrentStatus(overCurrentStatus),
    .powerStatus(powerStatus), .linkStateStatus(linkStateStatus),
    .speedStatus(speedStatus), .portChangeField(portChangeField),
    .startReset(startReset), .startWarmReset(startWarmReset));

  // ==========================================================================
  // Helpers.
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wrap_up;
    $display("TB: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Nothing here waits open-ended, but a stuck run still ends in the report.
  initial begin
    repeat (2000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    {hubLocalPowerChange, hubLocalPowerStatus, resetEntryOk, overCurrent} = 4'h0;
    {linkStateEvent, linkConfigFail, warmResetActive} = 3'h0;
    linkState = 4'h0;
    portState = hpsc_pkg::PS_POWERED_OFF;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    portState = hpsc_pkg::PS_DISCONNECT;
    cyc(1);
    `CHK("change field", hpsc_pkg::CHG_RESET_VAL, portChangeField)
    `CHK("speed", hpsc_pkg::SPEED_5G, speedStatus)
    `CHK("power", 1'b0, powerStatus)
    $display("TB: test reset values done");
    hubLocalPowerChange = 1'b1;
    hubLocalPowerStatus = 1'b1;
    hpsc_host_model_i.request(1'b1, hpsc_pkg::FEAT_POWER);
    `CHK("power", 1'b0, powerStatus)
    hubLocalPowerStatus = 1'b0;
    hpsc_host_model_i.request(1'b1, hpsc_pkg::FEAT_POWER);
    `CHK("power", 1'b1, powerStatus)
    `CHK("change field", 16'h0000, portChangeField)
    $display("TB: test power done");
    resetEntryOk = 1'b1;
    hpsc_host_model_i.request(1'b1, hpsc_pkg::FEAT_RESET);
    `CHK("reset pulse", 1'b1, startReset)
    cyc(1);
    `CHK("reset pulse", 1'b0, startReset)
    portState = hpsc_pkg::PS_RESETTING;
    cyc(2);
    `CHK("reset status", 1'b1, resetStatus)
    hpsc_host_model_i.request(1'b0, hpsc_pkg::FEAT_RESET);
    `CHK("reset status", 1'b1, resetStatus)
    portState = hpsc_pkg::PS_ENABLED;
    cyc(2);
    `CHK("reset status", 1'b0, resetStatus)
    `CHK("enabled", 1'b1, enabledStatus)
    `CHK("connect", 1'b1, connectStatus)
    `CHK("reset bits", 16'h0010, portChangeField & 16'h0030)
    hpsc_host_model_i.request(1'b1, hpsc_pkg::FEAT_WARM_RESET);
    `CHK("warm pulse", 1'b1, startWarmReset)
    portState = hpsc_pkg::PS_RESETTING;
    warmResetActive = 1'b1;
    cyc(2);
    portState = hpsc_pkg::PS_ENABLED;
    cyc(2);
    warmResetActive = 1'b0;
    `CHK("reset bits", 16'h0030, portChangeField & 16'h0030)
    hpsc_host_model_i.request(1'b0, hpsc_pkg::FEAT_C_RESET);
    hpsc_host_model_i.request(1'b0, hpsc_pkg::FEAT_C_WARM_RESET);
    hpsc_host_model_i.request(1'b0, hpsc_pkg::FEAT_C_CONNECTION);
    `CHK("change field", 16'h0000, portChangeField)
    $display("TB: test port reset done");
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      case (i)
        0: overCurrent = 1'b1;
        1: linkStateEvent = 1'b1;
        default: linkConfigFail = 1'b1;
      endcase
      @(negedge sys_clk);
      linkStateEvent = 1'b0;
      linkConfigFail = 1'b0;
      cyc(1);
      `CHK("event bit", 16'h0001 << evBit[i], portChangeField)
      hpsc_host_model_i.request(1'b0, evClr[i]);
      `CHK("change field", 16'h0000, portChangeField)
    end
    `CHK("over-current", 1'b1, overCurrentStatus)
    linkState = 4'h5;
    cyc(2);
    `CHK("link state", 4'h5, linkStateStatus)
    hpsc_host_model_i.request(1'b0, hpsc_pkg::FEAT_LINK_STATE);
    `CHK("link state", 4'h5, linkStateStatus)
    $display("TB: test change events done");
    hpsc_host_model_i.request(1'b1, hpsc_pkg::FEAT_C_LINK_STATE);
    `CHK("change field", 16'h0040, portChangeField)
    hpsc_host_model_i.request(1'b1, 5'h11);
    hpsc_host_model_i.request(1'b1, 5'h12);
    `CHK("change field", 16'h0040, portChangeField)
    $display("TB: test diagnostic set done");
    portState = hpsc_pkg::PS_DISCONNECT;
    cyc(2);
    `CHK("connect", 1'b0, connectStatus)
    portState = hpsc_pkg::PS_ENABLED;
    cyc(2);
    `CHK("change field", 16'h0041, portChangeField)
    hpsc_host_model_i.request(1'b0, hpsc_pkg::FEAT_C_CONNECTION);
    `CHK("change field", 16'h0040, portChangeField)
    $display("TB: test connect change done");
    portState = hpsc_pkg::PS_POWERED_OFF;
    cyc(2);
    `CHK("power", 1'b0, powerStatus)
    `CHK("change field", 16'h0000, portChangeField)
    `CHK("enabled", 1'b0, enabledStatus)
    $display("TB: test power off done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
